/* File: src/mfs_map.vh */
/*
  Register map, field positions, reset values and state codes of the
  multifunction light switch.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
`ifndef MFS_MAP_VH
`define MFS_MAP_VH

// Register byte offsets
`define MFS_CTRL_OFS      8'h00
`define MFS_TOFF_OFS      8'h04
`define MFS_TPERM_OFS     8'h08
`define MFS_TWARN_OFS     8'h0C
`define MFS_TWLEN_OFS     8'h10
`define MFS_SRC_OFS       8'h14
`define MFS_STATUS_OFS    8'h18

// Control register fields
`define MFS_CTRL_WARN_EN  0
`define MFS_CTRL_RETAIN   1
`define MFS_CTRL_LIVE_LO  4
`define MFS_CTRL_LIVE_HI  7

// Source register: one block-number nibble per timing parameter
`define MFS_SRC_NIB_W     4

// Status register fields
`define MFS_STAT_Q        0
`define MFS_STAT_ST_LO    1
`define MFS_STAT_ST_HI    2
`define MFS_STAT_ET_LO    16

// Reset values
`define MFS_CTRL_RST      32'h0000_0000
`define MFS_TOFF_RST      16'h000A
`define MFS_TPERM_RST     16'h0005
`define MFS_TWARN_RST     16'h0002
`define MFS_TWLEN_RST     16'h0001
`define MFS_SRC_RST       16'h0000

// Timing parameter slots
`define MFS_P_TOFF        0
`define MFS_P_TPERM       1
`define MFS_P_TWARN       2
`define MFS_P_TWLEN       3
`define MFS_NPARAM        4

// States
`define MFS_ST_IDLE       2'h0
`define MFS_ST_HOLD       2'h1
`define MFS_ST_DELAY      2'h2
`define MFS_ST_PERM       2'h3

`endif

/* File: src/mfs_param_sel.v */
/*
  Source selector for one timing parameter: either the programmed constant
  or the live actual value of another function block chosen by number.
  Assumes the live values arrive as one flat bus, block 0 in the low bits.
*/
module mfs_param_sel #(
  parameter TW   = 16,
  parameter NBLK = 8,
  parameter SW   = 4
) (
  // Selection
  input  wire                use_live,
  input  wire [SW-1:0]       blk_num,
  input  wire [TW-1:0]       const_val,
  // Live values of the other blocks
  input  wire [NBLK*TW-1:0]  blk_values,
  // Chosen value
  output reg  [TW-1:0]       val
);

  integer i;

  always @* begin
    val = const_val;
    if (use_live) begin
      // Unknown block numbers fall back to zero rather than aliasing
      val = {TW{1'b0}};
      for (i = 0; i < NBLK; i = i + 1) begin
        if (blk_num == i[SW-1:0])
          val = blk_values[i*TW +: TW];
      end
    end
  end

endmodule // mfs_param_sel

/* File: src/mfs_switch.v */
/*
  Multifunction light switch: pulse switch with off-delay, permanent light
  after a long press, optional pre-warning, clear input and retentivity,
  with its settings and state reached over APB.
  Assumes trigger, clear, tick and power-restore inputs are synchronous to
  clk; tick_in is a one-cycle pulse of the common timebase.
*/
// The address map and the APB register port were chosen for this implementation.
`include "mfs_map.vh"

// Operation
// [RL1] Rising trigger switches the output on
// [RL2] Long hold from off enters permanent light
// [RL3] Early release starts the off-delay
// [RL4] Output drops when elapsed reaches off-delay
// [RL5] Pre-warning drops output briefly before expiry
// [RL6] Further trigger while active clears everything
// [RL7] Clear input zeroes elapsed time, output low
// [RL8] Retentive keeps state over power loss
// [RL9] All times share one timebase
// [RL10] Each time: constant or live block value
// [RL11] Clear beats a simultaneous trigger edge
// [RL12] Elapsed time counts timebase ticks while timing
module mfs_switch #(
  parameter TW   = 16,
  parameter NBLK = 8
) (
  // Clock and reset
  input  wire                clk,
  input  wire                rst,
  // APB slave
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [7:0]          paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  // Switch inputs
  input  wire                trg_in,
  input  wire                clear_in,
  input  wire                tick_in,
  input  wire                pwr_restore,
  // Live actual values of other blocks
  input  wire [NBLK*TW-1:0]  blk_values,
  // Switched output and elapsed time
  output reg                 q_out,
  output reg  [TW-1:0]       elapsed_time
);

  localparam SW = `MFS_SRC_NIB_W;

  // Configuration registers
  reg  [31:0]        ctrl_reg;
  reg  [TW-1:0]      toff_reg;
  reg  [TW-1:0]      tperm_reg;
  reg  [TW-1:0]      twarn_reg;
  reg  [TW-1:0]      twlen_reg;
  reg  [4*SW-1:0]    src_reg;

  // Switch state
  reg  [1:0]         state_reg;
  reg  [1:0]         state_next;
  reg  [TW-1:0]      hold_reg;
  reg  [TW-1:0]      hold_next;
  reg  [TW-1:0]      elapsed_next;
  reg                q_next;
  reg                trg_d_reg;

  // Chosen timing values
  wire [4*TW-1:0]    const_bus;
  wire [4*TW-1:0]    param_bus;
  wire [TW-1:0]      t_off;
  wire [TW-1:0]      t_perm;
  wire [TW-1:0]      t_warn;
  wire [TW-1:0]      t_wlen;
  wire [TW-1:0]      warn_start;
  wire [TW:0]        warn_end;
  wire               trg_rise;
  wire               warn_en;
  wire               retain;

  // Bus phases
  wire               apb_setup;
  wire               apb_wr;

  assign const_bus  = {twlen_reg, twarn_reg, tperm_reg, toff_reg};
  assign t_off      = param_bus[`MFS_P_TOFF*TW +: TW];
  assign t_perm     = param_bus[`MFS_P_TPERM*TW +: TW];
  assign t_warn     = param_bus[`MFS_P_TWARN*TW +: TW];
  assign t_wlen     = param_bus[`MFS_P_TWLEN*TW +: TW];
  assign warn_en    = ctrl_reg[`MFS_CTRL_WARN_EN];
  assign retain     = ctrl_reg[`MFS_CTRL_RETAIN];
  assign trg_rise   = trg_in & ~trg_d_reg;
  assign apb_setup  = psel & ~penable;
  assign apb_wr     = psel & penable & pready & pwrite;

  // A lead longer than the off-delay starts the warning at once
  assign warn_start = (t_warn > t_off) ? {TW{1'b0}} : t_off - t_warn;
  assign warn_end   = {1'b0, warn_start} + {1'b0, t_wlen};

  // Each timing value may come from a constant or a live block value
  genvar g;
  generate
    for (g = 0; g < `MFS_NPARAM; g = g + 1) begin : g_sel
      mfs_param_sel #(
        .TW   (TW),
        .NBLK (NBLK),
        .SW   (SW)
      ) u_sel (
        .use_live   (ctrl_reg[`MFS_CTRL_LIVE_LO + g]),
        .blk_num    (src_reg[g*SW +: SW]),
        .const_val  (const_bus[g*TW +: TW]),
        .blk_values (blk_values),
        .val        (param_bus[g*TW +: TW])
      ); // RL10
    end
  endgenerate

  // Known register offsets
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `MFS_CTRL_OFS)  || (a == `MFS_TOFF_OFS)  ||
                  (a == `MFS_TPERM_OFS) || (a == `MFS_TWARN_OFS) ||
                  (a == `MFS_TWLEN_OFS) || (a == `MFS_SRC_OFS)   ||
                  (a == `MFS_STATUS_OFS);
    end
  endfunction

  // Pre-warning window: output dropped while elapsed time lies inside it
  function in_warn;
    input [TW-1:0] et;
    input          en;
    input [TW-1:0] ws;
    input [TW:0]   we;
    begin
      in_warn = en && (et >= ws) && ({1'b0, et} < we);
    end
  endfunction

  // Switch behaviour
  always @* begin
    state_next   = state_reg;
    hold_next    = hold_reg;
    elapsed_next = elapsed_time;
    q_next       = q_out;
    if (clear_in) begin
      state_next   = `MFS_ST_IDLE; // RL11
      hold_next    = {TW{1'b0}};
      elapsed_next = {TW{1'b0}}; // RL7
      q_next       = 1'b0; // RL7
    end else if (pwr_restore && !retain) begin
      // Non-retentive: state falls back to defaults after power loss
      state_next   = `MFS_ST_IDLE; // RL8
      hold_next    = {TW{1'b0}};
      elapsed_next = {TW{1'b0}}; // RL8
      q_next       = 1'b0; // RL8
    end else begin
      case (state_reg)
        `MFS_ST_IDLE: begin
          if (trg_rise) begin
            state_next   = `MFS_ST_HOLD;
            hold_next    = {TW{1'b0}};
            elapsed_next = {TW{1'b0}};
            q_next       = 1'b1; // RL1
          end
        end
        `MFS_ST_HOLD: begin
          if (!trg_in) begin
            state_next   = `MFS_ST_DELAY; // RL3
            elapsed_next = {TW{1'b0}}; // RL3
            q_next       = !in_warn({TW{1'b0}}, warn_en, warn_start, warn_end);
          end else if (hold_reg >= t_perm) begin
            state_next = `MFS_ST_PERM; // RL2
            q_next     = 1'b1; // RL2
          end else if (tick_in) begin
            hold_next = hold_reg + {{(TW-1){1'b0}}, 1'b1};
          end
        end
        `MFS_ST_DELAY: begin
          if (trg_rise) begin
            state_next   = `MFS_ST_IDLE; // RL6
            elapsed_next = {TW{1'b0}}; // RL6
            q_next       = 1'b0; // RL6
          end else if (elapsed_time >= t_off) begin
            state_next = `MFS_ST_IDLE;
            q_next     = 1'b0; // RL4
          end else begin
            if (tick_in)
              elapsed_next = elapsed_time + {{(TW-1){1'b0}}, 1'b1}; // RL12
            // Output follows the warning window one cycle behind the count
            q_next = !in_warn(elapsed_time, warn_en, warn_start, warn_end); // RL5
          end
        end
        `MFS_ST_PERM: begin
          if (trg_rise) begin
            state_next   = `MFS_ST_IDLE; // RL6
            elapsed_next = {TW{1'b0}}; // RL6
            q_next       = 1'b0; // RL6
          end
        end
        default: begin
          state_next   = `MFS_ST_IDLE;
          elapsed_next = {TW{1'b0}};
          q_next       = 1'b0;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      state_reg    <= `MFS_ST_IDLE;
      hold_reg     <= {TW{1'b0}};
      elapsed_time <= {TW{1'b0}};
      q_out        <= 1'b0;
      trg_d_reg    <= 1'b0;
    end else begin
      state_reg    <= state_next;
      hold_reg     <= hold_next;
      elapsed_time <= elapsed_next;
      q_out        <= q_next;
      trg_d_reg    <= trg_in;
    end
  end

  // APB: zero-wait answer, data and error prepared in the setup cycle
  always @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~is_mapped(paddr);
      if (apb_setup && !pwrite) begin
        case (paddr)
          `MFS_CTRL_OFS:   prdata <= ctrl_reg;
          `MFS_TOFF_OFS:   prdata <= {{(32-TW){1'b0}}, toff_reg};
          `MFS_TPERM_OFS:  prdata <= {{(32-TW){1'b0}}, tperm_reg};
          `MFS_TWARN_OFS:  prdata <= {{(32-TW){1'b0}}, twarn_reg};
          `MFS_TWLEN_OFS:  prdata <= {{(32-TW){1'b0}}, twlen_reg};
          `MFS_SRC_OFS:    prdata <= {{(32-4*SW){1'b0}}, src_reg};
          `MFS_STATUS_OFS: prdata <= {elapsed_time, 13'h0000, state_reg, q_out};
          default:         prdata <= 32'h0000_0000;
        endcase
      end else if (apb_setup) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Configuration writes; only the implemented control bits are stored
  always @(posedge clk) begin
    if (rst) begin
      ctrl_reg  <= `MFS_CTRL_RST;
      toff_reg  <= `MFS_TOFF_RST;
      tperm_reg <= `MFS_TPERM_RST;
      twarn_reg <= `MFS_TWARN_RST;
      twlen_reg <= `MFS_TWLEN_RST;
      src_reg   <= `MFS_SRC_RST;
    end else if (apb_wr) begin
      case (paddr)
        `MFS_CTRL_OFS:  ctrl_reg  <= pwdata & 32'h0000_00F3;
        `MFS_TOFF_OFS:  toff_reg  <= pwdata[TW-1:0]; // RL9
        `MFS_TPERM_OFS: tperm_reg <= pwdata[TW-1:0];
        `MFS_TWARN_OFS: twarn_reg <= pwdata[TW-1:0];
        `MFS_TWLEN_OFS: twlen_reg <= pwdata[TW-1:0];
        `MFS_SRC_OFS:   src_reg   <= pwdata[4*SW-1:0];
        default: begin
        end
      endcase
    end
  end

endmodule // mfs_switch

/* File: tb/mfs_sva.sv */
/* Port checker for mfs_switch.
   Assumes one clock and a synchronous active-high reset. */
module mfs_sva #(
  parameter TW = 16
) (
  // Clock, reset
  input wire logic          clk,
  input wire logic          rst,
  // APB
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [7:0]    paddr,
  input wire logic          pready,
  input wire logic          pslverr,
  // Switch
  input wire logic          trg_in,
  input wire logic          clear_in,
  input wire logic          tick_in,
  input wire logic          pwr_restore,
  input wire logic          q_out,
  input wire logic [TW-1:0] elapsed_time
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire quiet = !clear_in && !pwr_restore;
  sequence s_setup; psel && !penable; endsequence
  sequence s_rise; $rose(trg_in) && quiet; endsequence
  AST_ON: assert property (s_rise ##0 (!q_out && elapsed_time == 0) |=> q_out)
    else $error("output not on");
  AST_RETRG: assert property (s_rise ##0 q_out |=> !q_out && elapsed_time == 0)
    else $error("retrigger did not clear");
  AST_CLR: assert property (clear_in |=> !q_out && elapsed_time == 0)
    else $error("clear ignored");
  AST_HOLD: assert property (!tick_in && quiet && !$rose(trg_in) && !$fell(trg_in)
    |=> $stable(elapsed_time))
    else $error("elapsed moved without tick");
  AST_CNT: assert property (!$rose(trg_in) && tick_in && quiet && q_out
    && elapsed_time == 1 |=> elapsed_time == 2)
    else $error("tick not counted");
  AST_RDY: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  AST_ONE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_ERR: assert property (pready && paddr > 8'h18 |-> pslverr)
    else $error("unmapped not refused");
endmodule // mfs_sva

bind mfs_switch mfs_sva #(.TW(TW)) u_sva (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .trg_in(trg_in), .clear_in(clear_in),
  .tick_in(tick_in), .pwr_restore(pwr_restore), .q_out(q_out),
  .elapsed_time(elapsed_time)
);

/* File: tb/mfs_button.sv */
/* Pushbutton at the trigger input.
   Assumes the caller resumes just after a rising edge. */
module mfs_button (
  // Clock
  input wire logic clk,
  // Trigger line
  output     logic trg_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial trg_in = 1'b0;
  // Released for a cycle after each press so the next rise is seen
  task automatic push(input int n);
    @(posedge clk) trg_in <= 1'b1;
    repeat (n) @(posedge clk);
    trg_in <= 1'b0;
    @(posedge clk);
  endtask
endmodule // mfs_button

/* File: tb/mfs_switch_tb.sv */
/* Self-checking bench for mfs_switch.
   Assumes one-cycle APB access and times counted in tick_in pulses. */
module mfs_switch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] TOFF = 16'h000A;
  logic         clk, rst, psel, penable, pwrite, pready, pslverr;
  logic         clear_in, tick_in, pwr_restore, q_out;
  wire          trg_in;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata;
  logic [127:0] blk_values;
  logic [15:0]  elapsed_time, lv;
  logic [32:0]  e, exp_q[$];
  int           miscompares, total_checks;
  logic [7:0]   ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
  logic [31:0]  rv[7] = '{32'h0, 32'hA, 32'h5, 32'h2, 32'h1, 32'h0, 32'h0};

  mfs_switch #(.TW(16), .NBLK(8)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trg_in(trg_in), .clear_in(clear_in), .tick_in(tick_in),
    .pwr_restore(pwr_restore), .blk_values(blk_values), .q_out(q_out),
    .elapsed_time(elapsed_time)
  );
  mfs_button btn (.clk(clk), .trg_in(trg_in));

  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    if (!w) exp_q.push_back({a > 8'h18, d});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_q(input logic v);
    int n;
    n = 0;
    while (q_out !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("wait", 1, n < 400);
  endtask
  task automatic clr;
    @(posedge clk) clear_in <= 1'b1;
    @(posedge clk) clear_in <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pwr;
    @(posedge clk) pwr_restore <= 1'b1;
    @(posedge clk) pwr_restore <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  always @(posedge clk) tick_in <= ($urandom % 3) == 0;
  // Scoreboard: oldest expected read against each completed read
  always @(posedge clk) if (psel && penable && pready && !pwrite) begin
    e = exp_q.pop_front();
    chk("prdata", e[31:0], prdata);
    chk("pslverr", e[32], pslverr);
  end

  initial begin
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    clear_in    = 1'b0;
    pwr_restore = 1'b0;
    rst = 1'b1;
    void'($urandom(32'hC994));
    blk_values = {$urandom, $urandom, $urandom, $urandom};
    lv = 16'h0002 + 16'($urandom % 4);
    blk_values[48 +: 16] = lv;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) apb(0, ra[i], rv[i]);
    btn.push(2);
    chk("on", 1, q_out);
    wait_q(0);
    chk("off", 1, elapsed_time >= TOFF);
    btn.push(40);
    repeat (60) @(posedge clk);
    chk("perm", 1, q_out);
    apb(0, 8'h18, 32'h0000_0007);
    btn.push(1);
    chk("retrig", 0, {q_out, elapsed_time});
    apb(1, 8'h00, 32'h1);
    btn.push(1);
    wait_q(0);
    chk("warn", 1, elapsed_time >= TOFF - 2 && elapsed_time < TOFF);
    wait_q(1);
    wait_q(0);
    chk("w_end", 1, elapsed_time >= TOFF);
    apb(1, 8'h00, 32'h0);
    fork
      btn.push(1);
      clr();
    join
    chk("prio", 0, q_out);
    btn.push(1);
    repeat (6) @(posedge clk);
    clr();
    chk("clr", 0, {q_out, elapsed_time});
    apb(1, 8'h00, 32'h2);
    btn.push(1);
    pwr();
    chk("keep", 1, q_out);
    apb(1, 8'h00, 32'h0);
    pwr();
    chk("lose", 0, {q_out, elapsed_time});
    apb(1, 8'h14, 32'h3);
    apb(1, 8'h00, 32'h10);
    apb(0, 8'h00, 32'h10);
    btn.push(1);
    wait_q(0);
    chk("live", 1, elapsed_time >= lv && elapsed_time < TOFF);
    // Random clear and power pulses across presses; the checker judges each cycle
    repeat (8) begin
      fork
        btn.push(1 + $urandom % 8);
        repeat (12) @(posedge clk) begin
          clear_in    <= ($urandom % 8) == 0;
          pwr_restore <= ($urandom % 8) == 0;
        end
      join
    end
    @(posedge clk) pwr_restore <= 1'b0;
    clr();
    chk("rand", 0, {q_out, elapsed_time});
    stop_test();
  end
endmodule // mfs_switch_tb
